// ==== hw/cad_pkg.sv ====
// Shared constants for the addressing and low-power control core.
// Assumes a single 125 MHz clock domain and an internal byte-wide bus.
package cad_pkg;
    localparam int CAD_ADDR_W = 16;
    localparam int CAD_DATA_W = 8;
    localparam logic [15:0] CAD_RESET_VECTOR = 16'hFFFE;
    localparam logic [15:0] CAD_SWI_VECTOR = 16'hFFFC;
    localparam logic [15:0] CAD_IRQ_VECTOR = 16'hFFFA;
    localparam logic [7:0] CAD_SP_RESET = 8'hFF;
    localparam logic [9:0] CAD_SP_HIGH = 10'h003;
    localparam logic [7:0] CAD_ZERO_PAGE_TOP = 8'hFF;
    // Flag positions in condition_flags
    localparam int CAD_FLAG_C = 0;
    localparam int CAD_FLAG_Z = 1;
    localparam int CAD_FLAG_N = 2;
    localparam int CAD_FLAG_I = 3;
    localparam int CAD_FLAG_H = 4;
    localparam logic [4:0] CAD_FLAGS_RESET = 5'h08;
    // Opcodes (high nibble selects group, low nibble the operation)
    localparam logic [3:0] CAD_GRP_BTB = 4'h0;
    localparam logic [3:0] CAD_GRP_BSC = 4'h1;
    localparam logic [3:0] CAD_GRP_REL = 4'h2;
    localparam logic [3:0] CAD_GRP_INHA = 4'h4;
    localparam logic [3:0] CAD_GRP_CTL = 4'h8;
    localparam logic [3:0] CAD_GRP_CTL2 = 4'h9;
    localparam logic [3:0] CAD_GRP_IMM = 4'hA;
    localparam logic [3:0] CAD_GRP_DIR = 4'hB;
    localparam logic [3:0] CAD_GRP_EXT = 4'hC;
    localparam logic [3:0] CAD_GRP_IX2 = 4'hD;
    localparam logic [3:0] CAD_GRP_IX1 = 4'hE;
    localparam logic [3:0] CAD_GRP_IX = 4'hF;
    localparam logic [7:0] CAD_OP_RTI = 8'h80;
    localparam logic [7:0] CAD_OP_RTS = 8'h81;
    localparam logic [7:0] CAD_OP_SWI = 8'h83;
    localparam logic [7:0] CAD_OP_STOP = 8'h8E;
    localparam logic [7:0] CAD_OP_WAIT = 8'h8F;
    localparam logic [7:0] CAD_OP_TAX = 8'h97;
    localparam logic [7:0] CAD_OP_CLC = 8'h98;
    localparam logic [7:0] CAD_OP_SEC = 8'h99;
    localparam logic [7:0] CAD_OP_CLI = 8'h9A;
    localparam logic [7:0] CAD_OP_SEI = 8'h9B;
    localparam logic [7:0] CAD_OP_RSP = 8'h9C;
    localparam logic [7:0] CAD_OP_NOP = 8'h9D;
    localparam logic [7:0] CAD_OP_TXA = 8'h9F;
    // Low nibble inside register/memory groups
    localparam logic [3:0] CAD_SUB_LDA = 4'h6;
    localparam logic [3:0] CAD_SUB_STA = 4'h7;
    localparam logic [3:0] CAD_SUB_JMP = 4'hC;
    localparam logic [3:0] CAD_SUB_LDX = 4'hE;
    localparam logic [3:0] CAD_SUB_STX = 4'hF;

    typedef enum logic [12:0] {
        CAD_FETCH = 13'h0001,
        CAD_OPER1 = 13'h0002,
        CAD_OPER2 = 13'h0004,
        CAD_READ = 13'h0008,
        CAD_WRITE = 13'h0010,
        CAD_PUSH = 13'h0020,
        CAD_PULL = 13'h0040,
        CAD_VECT_HI = 13'h0080,
        CAD_VECT_LO = 13'h0100,
        CAD_STOPPED = 13'h0200,
        CAD_WAITING = 13'h0400,
        CAD_RESET_HI = 13'h0800,
        CAD_RESET_LO = 13'h1000
    } cad_state_t;
endpackage : cad_pkg

// ==== hw/cad_ea_unit.sv ====
// Effective address former for the addressing modes.
// Assumes operand bytes are already captured by the sequencer.
`timescale 1ns/1ps
module cad_ea_unit import cad_pkg::*; (
    input wire logic [3:0] group,     // Opcode group
    input wire logic [7:0] oper1,     // First byte after opcode
    input wire logic [7:0] oper2,     // Second byte after opcode
    input wire logic [7:0] indexVal,  // Index register
    output logic [15:0] effAddr       // Effective address
);
    always_comb begin
        unique case (group)
            CAD_GRP_BTB, CAD_GRP_BSC, CAD_GRP_DIR: effAddr = {8'h00, oper1};
            CAD_GRP_EXT: effAddr = {oper1, oper2};
            CAD_GRP_IX: effAddr = {8'h00, indexVal};
            CAD_GRP_IX1: effAddr = {8'h00, oper1} + {8'h00, indexVal};
            CAD_GRP_IX2: effAddr = {oper1, oper2} + {8'h00, indexVal};
            default: effAddr = 16'h0000;
        endcase
    end
endmodule : cad_ea_unit

// ==== hw/cad_bit_unit.sv ====
// Bit set, clear and test on a byte read from the lowest page.
// Assumes the opcode low nibble carries bit number and polarity.
`timescale 1ns/1ps
module cad_bit_unit import cad_pkg::*; (
    input wire logic [3:0] opLow,    // Opcode low nibble
    input wire logic [7:0] dataIn,   // Byte read back
    output logic [7:0] dataOut,      // Byte to write back
    output logic testedBit,          // Selected bit value
    output logic conditionMet        // Branch polarity matched
);
    logic [2:0] bitSel;
    logic [7:0] bitMask;
    assign bitSel = opLow[3:1];
    assign bitMask = 8'h01 << bitSel;
    assign testedBit = dataIn[bitSel];
    // Even code means branch on one / force one
    assign conditionMet = opLow[0] ? ~testedBit : testedBit;
    assign dataOut = opLow[0] ? (dataIn & ~bitMask) : (dataIn | bitMask);
endmodule : cad_bit_unit

// ==== hw/cad_core.sv ====
// Addressing, bit manipulation, control and low-power sequencer.
// Assumes a single-cycle synchronous byte bus toward memory and
// peripherals; wake and interrupt requests except timerIrq come from other clock trees.
// How it works
// - Set or clear any bit, lowest page
// - Tested bit copied into carry always
// - Immediate operand is the next byte
// - Direct: one byte address, zero-extended
// - Extended: two bytes form full address
// - Relative offset added only when taken
// - Indexed no offset: index zero-extended
// - Index plus unsigned byte, up to 510
// - Index plus unsigned two-byte offset
// - Bit number in opcode, address follows
// - Test-branch: opcode, address, signed offset
// - Inherent instructions are one byte
// - Branch high/low, force one/zero, eight bits
// - Transfer, carry, mask, trap, return, stop, wait
// - Stop gates main and sub clocks
// - Stop clears interrupt mask only
// - Stop ends on listed wake sources
// - Wait halts only CPU clocks
// - Wait ends on reset or interrupt
// - Time base dividers run during wait
// - Masked requests pend only while held by source
// - Mask set after flags pushed
`timescale 1ns/1ps
module cad_core import cad_pkg::*; (
    input wire logic ref_clk,         // 125 MHz clock
    input wire logic reset_n,         // Async reset, active low
    input wire logic clkEn,           // Freezes all state when low
    output logic [15:0] busAddr,      // Internal address bus
    output logic [7:0] busWdata,      // Write data
    output logic busRd,               // Read strobe
    output logic busWr,               // Write strobe
    input wire logic [7:0] busRdata,  // Read data, same cycle
    input wire logic timerIrq,        // Maskable timer request level
    input wire logic externalIrqPins, // External request level, async
    input wire logic keyWakeupIrq,    // Key wake request, async
    input wire logic serialSlaveIrq,  // Serial slave-mode request, async
    input wire logic timeBaseIrq,     // Time base request, async
    input wire logic timeBaseOnSub,   // Time base clocked by sub oscillator
    output logic mainOscillatorEn,    // Main oscillator run
    output logic subClockPathEn,      // Sub oscillator path to modules
    output logic cpuClockEn,          // CPU clock gate
    output logic timeBaseDivEn,       // Time base dividers run
    output logic [4:0] conditionFlags // Five flag bits for observation
);
    cad_state_t stateReg;
    logic [15:0] pcReg;
    logic [7:0] accReg;
    logic [7:0] indexReg;
    logic [5:0] spReg;
    logic [4:0] flagsReg;
    logic [7:0] opReg;
    logic [7:0] oper1Reg;
    logic [7:0] oper2Reg;
    logic [7:0] dataReg;
    logic [2:0] stackCnt;
    logic vectorSwi;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [15:0] effAddr;
    logic [7:0] bitOut;
    logic testedBit;
    logic conditionMet;
    logic [3:0] group;
    logic [3:0] opLow;
    logic anyIrq;
    logic irqPending;
    logic stopWake;
    logic [1:0] operCount;
    logic branchTaken;
    logic [15:0] relTarget;
    logic [7:0] pushByte;

    assign group = opReg[7:4];
    assign opLow = opReg[3:0];
    assign conditionFlags = flagsReg;

    // Two-stage synchronisers for the asynchronous request pins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA <= 4'h0;
            syncB <= 4'h0;
        end else if (clkEn) begin
            syncA <= {externalIrqPins, keyWakeupIrq, serialSlaveIrq, timeBaseIrq};
            syncB <= syncA;
        end
    end

    // Requests are levels held by their sources until serviced
    assign anyIrq = syncB[3] | syncB[2] | syncB[1] | syncB[0] | timerIrq;
    assign irqPending = anyIrq & ~flagsReg[CAD_FLAG_I];
    assign stopWake = syncB[3] | syncB[2] | syncB[1] | (syncB[0] & timeBaseOnSub);

    cad_ea_unit eaUnit (
        .group(group),
        .oper1(oper1Reg),
        .oper2(oper2Reg),
        .indexVal(indexReg),
        .effAddr(effAddr)
    );

    cad_bit_unit bitUnit (
        .opLow(opLow),
        .dataIn((stateReg == CAD_READ) ? busRdata : dataReg), // Test decides on the byte as it arrives
        .dataOut(bitOut),
        .testedBit(testedBit),
        .conditionMet(conditionMet)
    );

    // Bytes after the opcode, by group
    always_comb begin
        unique case (group)
            CAD_GRP_BTB, CAD_GRP_EXT, CAD_GRP_IX2: operCount = 2'd2;
            CAD_GRP_BSC, CAD_GRP_REL, CAD_GRP_IMM, CAD_GRP_DIR, CAD_GRP_IX1: operCount = 2'd1;
            default: operCount = 2'd0;
        endcase
    end

    // Relative branches on carry/zero/mask; unlisted codes never taken when even, always when odd
    always_comb begin
        unique case (opLow[3:1])
            3'h0: branchTaken = 1'b1;
            3'h2: branchTaken = ~(flagsReg[CAD_FLAG_C] | flagsReg[CAD_FLAG_Z]);
            3'h4: branchTaken = ~flagsReg[CAD_FLAG_C];
            3'h6: branchTaken = ~flagsReg[CAD_FLAG_Z];
            3'h7: branchTaken = ~flagsReg[CAD_FLAG_I];
            default: branchTaken = 1'b0;
        endcase
        if (opLow[0]) begin
            branchTaken = ~branchTaken;
        end
    end

    // Offset is the last instruction byte, relative to next opcode
    assign relTarget = pcReg + {{8{(group == CAD_GRP_BTB) ? oper2Reg[7] : oper1Reg[7]}},
                                (group == CAD_GRP_BTB) ? oper2Reg : oper1Reg};

    // Stacking order: PC low, PC high, index, accumulator, flags
    always_comb begin
        unique case (stackCnt)
            3'd0: pushByte = pcReg[7:0];
            3'd1: pushByte = pcReg[15:8];
            3'd2: pushByte = indexReg;
            3'd3: pushByte = accReg;
            default: pushByte = {3'b111, flagsReg};
        endcase
    end

    // Bus drive
    always_comb begin
        busAddr = pcReg;
        busWdata = 8'h00;
        busRd = 1'b0;
        busWr = 1'b0;
        unique case (stateReg)
            CAD_FETCH, CAD_OPER1, CAD_OPER2: busRd = 1'b1;
            CAD_READ: begin
                busAddr = effAddr;
                busRd = 1'b1;
            end
            CAD_WRITE: begin
                busAddr = effAddr;
                busWr = 1'b1;
                busWdata = (group == CAD_GRP_BSC) ? bitOut :
                           (opLow == CAD_SUB_STX) ? indexReg : accReg;
            end
            CAD_PUSH: begin
                busAddr = {CAD_SP_HIGH, spReg};
                busWr = 1'b1;
                busWdata = pushByte;
            end
            CAD_PULL: begin
                busAddr = {CAD_SP_HIGH, spReg + 6'd1};
                busRd = 1'b1;
            end
            CAD_VECT_HI, CAD_RESET_HI: begin
                busAddr = (stateReg == CAD_RESET_HI) ? CAD_RESET_VECTOR :
                          (vectorSwi ? CAD_SWI_VECTOR : CAD_IRQ_VECTOR);
                busRd = 1'b1;
            end
            CAD_VECT_LO, CAD_RESET_LO: begin
                busAddr = ((stateReg == CAD_RESET_LO) ? CAD_RESET_VECTOR :
                          (vectorSwi ? CAD_SWI_VECTOR : CAD_IRQ_VECTOR)) + 16'h0001;
                busRd = 1'b1;
            end
            CAD_STOPPED, CAD_WAITING: busAddr = pcReg;
        endcase
    end

    // Clock gating toward the rest of the chip
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mainOscillatorEn <= 1'b1;
            subClockPathEn <= 1'b1;
            cpuClockEn <= 1'b1;
            timeBaseDivEn <= 1'b1;
        end else if (clkEn) begin
            mainOscillatorEn <= (stateReg != CAD_STOPPED);
            subClockPathEn <= (stateReg != CAD_STOPPED);
            cpuClockEn <= (stateReg != CAD_STOPPED) && (stateReg != CAD_WAITING);
            // Dividers stay on in wait; only stop and sub-fed base differ
            timeBaseDivEn <= (stateReg != CAD_STOPPED) || timeBaseOnSub;
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= CAD_RESET_HI;
            pcReg <= 16'h0000;
            accReg <= 8'h00;
            indexReg <= 8'h00;
            spReg <= CAD_SP_RESET[5:0];
            flagsReg <= CAD_FLAGS_RESET;
            opReg <= CAD_OP_NOP;
            oper1Reg <= 8'h00;
            oper2Reg <= 8'h00;
            dataReg <= 8'h00;
            stackCnt <= 3'd0;
            vectorSwi <= 1'b0;
        end else if (clkEn) begin
            unique case (stateReg)
                CAD_RESET_HI: begin
                    pcReg[15:8] <= busRdata;
                    stateReg <= CAD_RESET_LO;
                end
                CAD_RESET_LO: begin
                    pcReg[7:0] <= busRdata;
                    stateReg <= CAD_FETCH;
                end
                CAD_FETCH: begin
                    if (irqPending) begin
                        vectorSwi <= 1'b0;
                        stackCnt <= 3'd0;
                        stateReg <= CAD_PUSH;
                    end else begin
                        opReg <= busRdata;
                        pcReg <= pcReg + 16'h0001;
                        if (busRdata[7:4] == CAD_GRP_BTB || busRdata[7:4] == CAD_GRP_EXT ||
                            busRdata[7:4] == CAD_GRP_IX2 || busRdata[7:4] == CAD_GRP_BSC ||
                            busRdata[7:4] == CAD_GRP_REL || busRdata[7:4] == CAD_GRP_IMM ||
                            busRdata[7:4] == CAD_GRP_DIR || busRdata[7:4] == CAD_GRP_IX1) begin
                            stateReg <= CAD_OPER1;
                        end else begin
                            stateReg <= (busRdata[7:4] == CAD_GRP_IX) ? CAD_READ : CAD_FETCH;
                            unique case (busRdata)
                                CAD_OP_TAX: indexReg <= accReg;
                                CAD_OP_TXA: accReg <= indexReg;
                                CAD_OP_CLC: flagsReg[CAD_FLAG_C] <= 1'b0;
                                CAD_OP_SEC: flagsReg[CAD_FLAG_C] <= 1'b1;
                                CAD_OP_CLI: flagsReg[CAD_FLAG_I] <= 1'b0;
                                CAD_OP_SEI: flagsReg[CAD_FLAG_I] <= 1'b1;
                                CAD_OP_RSP: spReg <= CAD_SP_RESET[5:0];
                                CAD_OP_STOP: begin
                                    flagsReg[CAD_FLAG_I] <= 1'b0;
                                    stateReg <= CAD_STOPPED;
                                end
                                CAD_OP_WAIT: begin
                                    flagsReg[CAD_FLAG_I] <= 1'b0;
                                    stateReg <= CAD_WAITING;
                                end
                                CAD_OP_SWI: begin
                                    vectorSwi <= 1'b1;
                                    stackCnt <= 3'd0;
                                    pcReg <= pcReg + 16'h0001;
                                    stateReg <= CAD_PUSH;
                                end
                                CAD_OP_RTI: begin
                                    stackCnt <= 3'd4;
                                    stateReg <= CAD_PULL;
                                end
                                CAD_OP_RTS: begin
                                    stackCnt <= 3'd1;
                                    stateReg <= CAD_PULL;
                                end
                                default: ;
                            endcase
                        end
                    end
                end
                CAD_OPER1: begin
                    oper1Reg <= busRdata;
                    pcReg <= pcReg + 16'h0001;
                    if (operCount == 2'd2) begin
                        stateReg <= CAD_OPER2;
                    end else if (group == CAD_GRP_IMM) begin
                        // Operand is this byte; no further access
                        if (opLow == CAD_SUB_LDX) indexReg <= busRdata;
                        else if (opLow == CAD_SUB_LDA) accReg <= busRdata;
                        stateReg <= CAD_FETCH;
                    end else if (group == CAD_GRP_REL) begin
                        stateReg <= CAD_FETCH;
                        if (branchTaken) begin
                            pcReg <= pcReg + 16'h0001 + {{8{busRdata[7]}}, busRdata};
                        end
                    end else begin
                        stateReg <= CAD_READ;
                    end
                end
                CAD_OPER2: begin
                    oper2Reg <= busRdata;
                    pcReg <= pcReg + 16'h0001;
                    stateReg <= CAD_READ;
                end
                CAD_READ: begin
                    dataReg <= busRdata;
                    stateReg <= CAD_FETCH;
                    if (group == CAD_GRP_BSC) begin
                        stateReg <= CAD_WRITE;
                    end else if (group == CAD_GRP_BTB) begin
                        flagsReg[CAD_FLAG_C] <= opLow[0] ? ~conditionMet : conditionMet;
                        if (conditionMet) pcReg <= relTarget;
                    end else if (opLow == CAD_SUB_JMP) begin
                        pcReg <= effAddr;
                    end else if (opLow == CAD_SUB_STA || opLow == CAD_SUB_STX) begin
                        stateReg <= CAD_WRITE;
                    end else if (opLow == CAD_SUB_LDA) begin
                        accReg <= busRdata;
                    end else if (opLow == CAD_SUB_LDX) begin
                        indexReg <= busRdata;
                    end
                end
                CAD_WRITE: stateReg <= CAD_FETCH;
                CAD_PUSH: begin
                    spReg <= spReg - 6'd1;
                    stackCnt <= stackCnt + 3'd1;
                    if (stackCnt == 3'd4) begin
                        flagsReg[CAD_FLAG_I] <= 1'b1;
                        stateReg <= CAD_VECT_HI;
                    end
                end
                CAD_PULL: begin
                    spReg <= spReg + 6'd1;
                    stackCnt <= stackCnt - 3'd1;
                    unique case (stackCnt)
                        3'd4: flagsReg <= busRdata[4:0];
                        3'd3: accReg <= busRdata;
                        3'd2: indexReg <= busRdata;
                        3'd1: pcReg[15:8] <= busRdata;
                        default: pcReg[7:0] <= busRdata;
                    endcase
                    if (stackCnt == 3'd0) stateReg <= CAD_FETCH;
                end
                CAD_VECT_HI: begin
                    pcReg[15:8] <= busRdata;
                    stateReg <= CAD_VECT_LO;
                end
                CAD_VECT_LO: begin
                    pcReg[7:0] <= busRdata;
                    stateReg <= CAD_FETCH;
                end
                CAD_STOPPED: begin
                    if (stopWake) stateReg <= CAD_FETCH;
                end
                CAD_WAITING: begin
                    if (anyIrq) stateReg <= CAD_FETCH;
                end
            endcase
        end
    end
endmodule : cad_core

// ==== dv/cad_mem_model.sv ====
// Byte memory answering the core's bus in the same cycle.
// Assumes the bench preloads program bytes through mem.
`timescale 1ns/1ps
module cad_mem_model (
    input wire logic ref_clk, // Clock
    input wire logic [15:0] busAddr, // Address
    input wire logic [7:0] busWdata, // Write data
    input wire logic busRd, // Read strobe
    input wire logic busWr, // Write strobe
    output logic [7:0] busRdata // Read data
);
    logic [7:0] mem [0:65535];
    logic [7:0] lastRd;
    // Idle data shows the inverse, so no stale byte passes
    assign busRdata = busRd ? mem[busAddr] : ~lastRd;
    initial begin
        lastRd = 8'h00;
        for (int a = 0; a < 65536; a++) mem[a] = 8'h00;
    end
    always @(posedge ref_clk) begin
        if (busRd) lastRd <= mem[busAddr];
        if (busWr) mem[busAddr] <= busWdata;
    end
endmodule : cad_mem_model

// ==== dv/cad_core_chk.sv ====
// Port-level assertions for the addressing and low-power core.
// Bound to cad_core; clkEn is held high around it.
`timescale 1ns/1ps
module cad_core_chk import cad_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Async reset
    input wire logic [15:0] busAddr, // Address
    input wire logic busRd, // Read strobe
    input wire logic busWr, // Write strobe
    input wire logic timerIrq, // Timer request
    input wire logic keyWakeupIrq, // Key wake
    input wire logic mainOscillatorEn, // Main oscillator
    input wire logic subClockPathEn, // Sub path
    input wire logic cpuClockEn, // CPU gate
    input wire logic timeBaseDivEn, // Dividers
    input wire logic [4:0] conditionFlags // Flags
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Settled wait, skipping the lag cycle of stop entry
    sequence waitSeq;
        !cpuClockEn && !$past(cpuClockEn) && mainOscillatorEn && $past(mainOscillatorEn);
    endsequence
    AST_STOP_GATES: assert property (!mainOscillatorEn |-> !subClockPathEn && !cpuClockEn)
        else $error("clock left running in stop");
    AST_WAIT_OSC: assert property (waitSeq |-> subClockPathEn)
        else $error("sub path off in wait");
    AST_WAIT_DIV: assert property (waitSeq |-> timeBaseDivEn)
        else $error("dividers off in wait");
    AST_SLEEP_MASK: assert property ($fell(cpuClockEn) |-> ##[0:1] !conditionFlags[CAD_FLAG_I])
        else $error("mask kept on sleep");
    AST_WAIT_WAKE: assert property (waitSeq ##0 timerIrq |-> ##[1:4] cpuClockEn)
        else $error("wait not left on request");
    AST_KEY_WAKE: assert property (!mainOscillatorEn && keyWakeupIrq |-> ##[1:6] mainOscillatorEn)
        else $error("stop not left on key");
    AST_VEC_PUSH: assert property (busRd && busAddr == CAD_IRQ_VECTOR |-> conditionFlags[CAD_FLAG_I] && $past(busWr))
        else $error("vector before push or mask");
    AST_MASK_OFF: assert property (busRd && busAddr == CAD_IRQ_VECTOR |-> !$past(conditionFlags[CAD_FLAG_I], 2))
        else $error("request taken while masked");
    COV_WAIT: cover property (waitSeq);
    COV_STOP: cover property (!mainOscillatorEn);
    COV_VEC: cover property (busRd && busAddr == CAD_IRQ_VECTOR);
endmodule : cad_core_chk
bind cad_core cad_core_chk chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .busAddr(busAddr), .busRd(busRd),
    .busWr(busWr), .timerIrq(timerIrq), .keyWakeupIrq(keyWakeupIrq), .mainOscillatorEn(mainOscillatorEn),
    .subClockPathEn(subClockPathEn), .cpuClockEn(cpuClockEn), .timeBaseDivEn(timeBaseDivEn),
    .conditionFlags(conditionFlags));

// ==== dv/cad_core_tb.sv ====
// Self-checking bench: program run, wait and stop wakeups.
// Assumes the core reads its reset vector from FFFE first.
`timescale 1ns/1ps
module cad_core_tb import cad_pkg::*;;
    logic ref_clk, reset_n, timerIrq, keyWakeupIrq, busRd, busWr;
    logic mainOscillatorEn, subClockPathEn, cpuClockEn, timeBaseDivEn;
    logic [15:0] busAddr;
    logic [7:0] busWdata, busRdata;
    logic [4:0] conditionFlags;
    int error_cnt = 0;
    int n_checks = 0;
    // Code at 0100; bit operations touch only plain memory
    localparam logic [7:0] PROG [36] = '{8'hA6, 8'h5A, 8'hB7, 8'h40, 8'h10, 8'h40, 8'h1D, 8'h40, 8'h0C, 8'h40,
        8'h7F, 8'h00, 8'h40, 8'h02, 8'hB7, 8'h42, 8'hAE, 8'hFF, 8'hF7, 8'hE7, 8'hFF, 8'hD7, 8'h12, 8'h34,
        8'hC7, 8'h20, 8'h00, 8'h9F, 8'hB7, 8'h41, 8'h9A, 8'h8F, 8'h8E, 8'hCC, 8'h01, 8'h21};
    cad_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1), .busAddr(busAddr), .busWdata(busWdata),
        .busRd(busRd), .busWr(busWr), .busRdata(busRdata), .timerIrq(timerIrq), .externalIrqPins(1'b0),
        .keyWakeupIrq(keyWakeupIrq), .serialSlaveIrq(1'b0), .timeBaseIrq(1'b0), .timeBaseOnSub(1'b0),
        .mainOscillatorEn(mainOscillatorEn), .subClockPathEn(subClockPathEn), .cpuClockEn(cpuClockEn),
        .timeBaseDivEn(timeBaseDivEn), .conditionFlags(conditionFlags));
    cad_mem_model mem_u (.ref_clk(ref_clk), .busAddr(busAddr), .busWdata(busWdata), .busRd(busRd),
        .busWr(busWr), .busRdata(busRdata));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait for a read or write at one address
    task wait_bus(input logic wr, input logic [15:0] addr, input logic noVec);
        for (int i = 0; i < 400; i++) begin
            @(negedge ref_clk);
            if (noVec && busRd === 1'b1 && busAddr === CAD_IRQ_VECTOR) check(8'h01, 8'h00);
            if ((wr ? busWr : busRd) === 1'b1 && busAddr === addr) return;
        end
        error_cnt++;
        complete_run();
    endtask : wait_bus
    task scenario_program;
        timerIrq = 1'b1;
        wait_bus(1'b1, 16'h0041, 1'b1);
        @(posedge ref_clk);
        #1;
        check(mem_u.mem[16'h0040], 8'h1B);
        check(mem_u.mem[16'h0042], 8'h00);
        check({7'h00, conditionFlags[CAD_FLAG_C]}, 8'h01);
        check(mem_u.mem[16'h00FF], 8'h5A);
        check(mem_u.mem[16'h01FE], 8'h5A);
        check(mem_u.mem[16'h1333], 8'h5A);
        check(mem_u.mem[16'h2000], 8'h5A);
        check(mem_u.mem[16'h0041], 8'hFF);
    endtask : scenario_program
    task scenario_wait;
        int i;
        // Held timer request is taken as soon as the mask clears
        wait_bus(1'b0, CAD_IRQ_VECTOR, 1'b0);
        timerIrq = 1'b0;
        check({7'h00, conditionFlags[CAD_FLAG_I]}, 8'h01);
        for (i = 0; i < 100 && cpuClockEn !== 1'b0; i++) @(negedge ref_clk);
        check({7'h00, cpuClockEn}, 8'h00);
        check({7'h00, mainOscillatorEn}, 8'h01);
        check({7'h00, timeBaseDivEn}, 8'h01);
        timerIrq = 1'b1;
        wait_bus(1'b0, CAD_IRQ_VECTOR, 1'b0);
        timerIrq = 1'b0;
        check({7'h00, cpuClockEn}, 8'h01);
    endtask : scenario_wait
    task scenario_stop;
        int i;
        for (i = 0; i < 100 && mainOscillatorEn !== 1'b0; i++) @(negedge ref_clk);
        check({7'h00, mainOscillatorEn}, 8'h00);
        timerIrq = 1'b1;
        repeat (20) @(negedge ref_clk);
        check({7'h00, mainOscillatorEn}, 8'h00);
        check({7'h00, timeBaseDivEn}, 8'h00);
        timerIrq = 1'b0;
        keyWakeupIrq = 1'b1;
        wait_bus(1'b0, CAD_IRQ_VECTOR, 1'b0);
        keyWakeupIrq = 1'b0;
        check({7'h00, mainOscillatorEn}, 8'h01);
    endtask : scenario_stop
    initial begin
        reset_n = 1'b0;
        timerIrq = 1'b0;
        keyWakeupIrq = 1'b0;
        #1;
        for (int k = 0; k < 36; k++) mem_u.mem[16'h0100 + k] = PROG[k];
        mem_u.mem[16'hFFFE] = 8'h01;
        mem_u.mem[16'hFFFA] = 8'h02;
        mem_u.mem[16'h0200] = 8'h80;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        scenario_program();
        scenario_wait();
        scenario_stop();
        repeat (20) @(negedge ref_clk);
        complete_run();
    end
endmodule : cad_core_tb
